// >>> core/dual_timer_counter.sv
`timescale 1ns/10ps
`default_nettype none
module dual_timer_counter (
    // Clock and reset.
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    // APB slave.
    input  wire tmr_pkg::apb_req_t     apb_i,
    output logic [31:0]                prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // External pins and service-routine entry strobes.
    input  wire tmr_pkg::timer_pins_t  pins_i,
    input  wire tmr_pkg::svc_enter_t   svc_enter_i,
    // Request flags and interrupt.
    output tmr_pkg::req_flags_t        flags_o,
    output logic                       irq_o
);
    import tmr_pkg::*;

    logic [7:0] op_cfg_reg;
    logic [7:0] c0_low_reg;
    logic [7:0] c0_high_reg;
    logic [7:0] c1_low_reg;
    logic [7:0] c1_high_reg;
    logic       div_sel_zero_reg;
    logic       div_sel_one_reg;
    logic       run_bit_zero;
    logic       run_bit_one;
    logic       overflow_flag_zero;
    logic       overflow_flag_one;
    logic       ext_irq_zero_request;
    logic       ext_irq_one_request;
    logic       ext_irq_zero_trigger_type;
    logic       ext_irq_one_trigger_type;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] prev_reg;
    logic [3:0] slow_cnt_reg;
    logic [1:0] fast_cnt_reg;
    logic       slow_tick;
    logic       fast_tick;
    logic       pready_reg;
    logic [31:0] prdata_reg;
    logic       pslverr_reg;

    // Bus decode.
    logic       wr_en;
    logic [7:0] wdata;
    logic [31:0] rd_data;
    logic       rd_hit;
    assign wr_en = apb_i.psel && apb_i.penable && apb_i.pwrite && pready_reg
                   && apb_i.pstrb[0];
    assign wdata = apb_i.pwdata[7:0];

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (apb_i.paddr == ADDR_RUN_CTRL) begin
            rd_data[7:0] = {overflow_flag_one, run_bit_one,
                            overflow_flag_zero, run_bit_zero,
                            ext_irq_one_request, ext_irq_one_trigger_type,
                            ext_irq_zero_request, ext_irq_zero_trigger_type};
        end else if (apb_i.paddr == ADDR_OP_CFG) begin
            rd_data[7:0] = op_cfg_reg;
        end else if (apb_i.paddr == ADDR_C0_LOW) begin
            rd_data[7:0] = c0_low_reg;
        end else if (apb_i.paddr == ADDR_C1_LOW) begin
            rd_data[7:0] = c1_low_reg;
        end else if (apb_i.paddr == ADDR_C0_HIGH) begin
            rd_data[7:0] = c0_high_reg;
        end else if (apb_i.paddr == ADDR_C1_HIGH) begin
            rd_data[7:0] = c1_high_reg;
        end else if (apb_i.paddr == ADDR_CLK_CTRL) begin
            rd_data[POS_DIV_SEL_ONE]  = div_sel_one_reg;
            rd_data[POS_DIV_SEL_ZERO] = div_sel_zero_reg;
        end else if (apb_i.paddr == ADDR_IRQ_STAT) begin
            rd_data[3:0] = irq_stat_reg;
        end else if (apb_i.paddr == ADDR_IRQ_MASK) begin
            rd_data[3:0] = irq_mask_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // One wait state: the answer is registered in the first access cycle.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (apb_i.psel && apb_i.penable && !pready_reg) begin
            pready_reg  <= 1'b1;
            prdata_reg  <= apb_i.pwrite ? 32'h0000_0000 : rd_data;
            pslverr_reg <= !rd_hit;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    logic wr_run, wr_cfg, wr_c0l, wr_c1l, wr_c0h, wr_c1h, wr_clk;
    logic wr_stat, wr_mask;
    assign wr_run  = wr_en && (apb_i.paddr == ADDR_RUN_CTRL) && !pslverr_reg;
    assign wr_cfg  = wr_en && (apb_i.paddr == ADDR_OP_CFG);
    assign wr_c0l  = wr_en && (apb_i.paddr == ADDR_C0_LOW);
    assign wr_c1l  = wr_en && (apb_i.paddr == ADDR_C1_LOW);
    assign wr_c0h  = wr_en && (apb_i.paddr == ADDR_C0_HIGH);
    assign wr_c1h  = wr_en && (apb_i.paddr == ADDR_C1_HIGH);
    assign wr_clk  = wr_en && (apb_i.paddr == ADDR_CLK_CTRL);
    assign wr_stat = wr_en && (apb_i.paddr == ADDR_IRQ_STAT);
    assign wr_mask = wr_en && (apb_i.paddr == ADDR_IRQ_MASK);

    // Pin synchronisers; edges are taken from the second stage only.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 4'hf;
            sync2_reg <= 4'hf;
            prev_reg  <= 4'hf;
        end else begin
            sync1_reg <= pins_i;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    logic pin1_s, pin0_s, ev1_fall, ev0_fall, pin1_fall, pin0_fall;
    assign pin1_s    = sync2_reg[3];
    assign pin0_s    = sync2_reg[2];
    assign pin1_fall = prev_reg[3] && !sync2_reg[3];
    assign pin0_fall = prev_reg[2] && !sync2_reg[2];
    assign ev1_fall  = prev_reg[1] && !sync2_reg[1];
    assign ev0_fall  = prev_reg[0] && !sync2_reg[0];

    // Internal count clock: one-cycle ticks at ref/12 and ref/4.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slow_cnt_reg <= 4'h0;
            fast_cnt_reg <= 2'h0;
        end else begin
            slow_cnt_reg <= slow_tick ? 4'h0 : slow_cnt_reg + 4'h1;
            fast_cnt_reg <= fast_tick ? 2'h0 : fast_cnt_reg + 2'h1;
        end
    end
    assign slow_tick = (slow_cnt_reg == DIV_SLOW_LAST);
    assign fast_tick = (fast_cnt_reg == DIV_FAST_LAST);

    logic int_tick0, int_tick1;
    assign int_tick0 = div_sel_zero_reg ? fast_tick : slow_tick;
    assign int_tick1 = div_sel_one_reg ? fast_tick : slow_tick;

    // One count step for modes 0 to 2; returns {overflow, high, low}.
    function automatic logic [16:0] count_step(input logic [1:0] mode,
                                               input logic [7:0] lo,
                                               input logic [7:0] hi);
        logic [16:0] r;
        r = {1'b0, hi, lo};
        case (mode)
            MODE_PRESCALE: begin
                r[4:0] = lo[4:0] + 5'h01;
                if (lo[4:0] == 5'h1f) begin
                    r[15:8] = hi + 8'h01;
                    r[16]   = (hi == 8'hff);
                end
            end
            MODE_WIDE: begin
                r[15:0] = {hi, lo} + 16'h0001;
                r[16]   = ({hi, lo} == 16'hffff);
            end
            MODE_RELOAD: begin
                r[7:0] = (lo == 8'hff) ? hi : lo + 8'h01;
                r[16]  = (lo == 8'hff);
            end
            default: begin
                r = {1'b0, hi, lo};
            end
        endcase
        return r;
    endfunction

    logic [3:0] cfg0, cfg1;
    logic [1:0] mode0, mode1;
    logic       split0;
    assign cfg0   = op_cfg_reg[3:0];
    assign cfg1   = op_cfg_reg[CFG_ONE_LSB +: 4];
    assign mode0  = cfg0[1:0];
    assign mode1  = cfg1[1:0];
    assign split0 = (mode0 == MODE_SPLIT);

    logic en0, en1, en0_high;
    logic [16:0] step0, step1;
    logic ovf0, ovf1, ovf0_high;
    // combine as run, gate level and count source.
    assign en0 = run_bit_zero && (!cfg0[POS_GATE] || pin0_s)
                 && (cfg0[POS_SRC] ? ev0_fall : int_tick0);
    // While counter zero is split, counter one's run bit belongs to the
    // high-byte timer, so counter one free-runs in its own mode.
    assign en1 = (run_bit_one || split0)
                 && (!cfg1[POS_GATE] || pin1_s)
                 && (cfg1[POS_SRC] ? ev1_fall : int_tick1)
                 && (mode1 != MODE_SPLIT);
    assign en0_high = split0 && run_bit_one && int_tick1;

    assign step0 = count_step(mode0, c0_low_reg, c0_high_reg);
    assign step1 = count_step(mode1, c1_low_reg, c1_high_reg);
    assign ovf0 = en0 && (split0 ? (c0_low_reg == 8'hff) : step0[16]);
    assign ovf0_high = en0_high && (c0_high_reg == 8'hff);
    assign ovf1 = en1 && step1[16] && !split0;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c0_low_reg  <= RST_BYTE;
            c0_high_reg <= RST_BYTE;
        end else begin
            if (wr_c0l) begin
                c0_low_reg <= wdata;
            end else if (en0 && split0) begin
                c0_low_reg <= c0_low_reg + 8'h01;
            end else if (en0) begin
                c0_low_reg <= step0[7:0];
            end
            if (wr_c0h) begin
                c0_high_reg <= wdata;
            end else if (en0_high) begin
                c0_high_reg <= c0_high_reg + 8'h01;
            end else if (en0 && !split0) begin
                c0_high_reg <= step0[15:8];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c1_low_reg  <= RST_BYTE;
            c1_high_reg <= RST_BYTE;
        end else begin
            if (wr_c1l) begin
                c1_low_reg <= wdata;
            end else if (en1) begin
                c1_low_reg <= step1[7:0];
            end
            if (wr_c1h) begin
                c1_high_reg <= wdata;
            end else if (en1) begin
                c1_high_reg <= step1[15:8];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_cfg_reg       <= RST_BYTE;
            div_sel_zero_reg <= 1'b0;
            div_sel_one_reg  <= 1'b0;
        end else begin
            if (wr_cfg) begin
                op_cfg_reg <= wdata;
            end
            if (wr_clk) begin
                div_sel_zero_reg <= wdata[POS_DIV_SEL_ZERO];
                div_sel_one_reg  <= wdata[POS_DIV_SEL_ONE];
            end
        end
    end

    // Overflow flags: the hardware set wins over any clear.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overflow_flag_zero <= 1'b0;
            overflow_flag_one  <= 1'b0;
            run_bit_zero       <= 1'b0;
            run_bit_one        <= 1'b0;
        end else begin
            if (wr_run) begin
                run_bit_zero <= wdata[POS_RUN_ZERO];
                run_bit_one  <= wdata[POS_RUN_ONE];
            end
            if (ovf0) begin
                overflow_flag_zero <= 1'b1;
            end else if (wr_run) begin
                overflow_flag_zero <= wdata[POS_OVF_ZERO];
            end else if (svc_enter_i.ovf_zero) begin
                overflow_flag_zero <= 1'b0;
            end
            if (ovf1 || ovf0_high) begin
                overflow_flag_one <= 1'b1;
            end else if (wr_run) begin
                overflow_flag_one <= wdata[POS_OVF_ONE];
            end else if (svc_enter_i.ovf_one) begin
                overflow_flag_one <= 1'b0;
            end
        end
    end

    // External requests: type 1 is falling edge, type 0 is low level.
    logic ext0_set, ext1_set;
    assign ext0_set = ext_irq_zero_trigger_type ? pin0_fall
                      : (!pin0_s && !ext_irq_zero_request);
    assign ext1_set = ext_irq_one_trigger_type ? pin1_fall
                      : (!pin1_s && !ext_irq_one_request);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_irq_zero_request      <= 1'b0;
            ext_irq_one_request       <= 1'b0;
            ext_irq_zero_trigger_type <= 1'b0;
            ext_irq_one_trigger_type  <= 1'b0;
        end else begin
            if (wr_run) begin
                ext_irq_zero_trigger_type <= wdata[POS_TYPE_ZERO];
                ext_irq_one_trigger_type  <= wdata[POS_TYPE_ONE];
            end
            if (!ext_irq_zero_trigger_type) begin
                ext_irq_zero_request <= !pin0_s;
            end else if (pin0_fall) begin
                ext_irq_zero_request <= 1'b1;
            end else if (wr_run) begin
                ext_irq_zero_request <= wdata[POS_REQ_ZERO];
            end else if (svc_enter_i.ext_zero) begin
                ext_irq_zero_request <= 1'b0;
            end
            if (!ext_irq_one_trigger_type) begin
                ext_irq_one_request <= !pin1_s;
            end else if (pin1_fall) begin
                ext_irq_one_request <= 1'b1;
            end else if (wr_run) begin
                ext_irq_one_request <= wdata[POS_REQ_ONE];
            end else if (svc_enter_i.ext_one) begin
                ext_irq_one_request <= 1'b0;
            end
        end
    end

    // Sticky event status, write one to clear; a new event wins.
    logic [3:0] events;
    logic [3:0] irq_stat_next;
    assign events = {ext1_set, ext0_set, ovf1 || ovf0_high, ovf0};
    assign irq_stat_next = (irq_stat_reg & ~(wr_stat ? wdata[3:0] : 4'h0))
                           | events;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_reg <= RST_NIBBLE;
            irq_mask_reg <= RST_NIBBLE;
            irq_o        <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr_mask) begin
                irq_mask_reg <= wdata[3:0];
            end
            irq_o <= |(irq_stat_next & (wr_mask ? wdata[3:0] : irq_mask_reg));
        end
    end

    assign prdata_o  = prdata_reg;
    assign pready_o  = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign flags_o   = {overflow_flag_one, overflow_flag_zero,
                        ext_irq_one_request, ext_irq_zero_request};

endmodule : dual_timer_counter // dual_timer_counter
`default_nettype wire

// >>> core/tmr_pkg.sv
// Summary of operation
// - Overflow sets the counter's flag; software may also set or clear it.
// - Entering a counter's service routine clears its overflow flag.
// - Run bit: writing 1 starts the counter, writing 0 stops it.
// - Selected edge or level on an interrupt pin sets its request flag.
// - Edge request clears on service entry; level request follows the pin.
// - Type bit picks falling-edge or low-level triggering per pin.
// - With gating set, count only while run is 1 and pin is high.
// - With gating clear, the pin is ignored and run alone enables.
// - Source bit 0 counts internal clock, 1 counts event pin falls.
// - Mode 0: high byte counts above a 5-bit low-byte prescaler.
// - Mode 1 (01): low and high bytes form a 16-bit counter.
// - Mode 2 (10): low byte counts, reloads from high byte on overflow.
// - Mode 3 on counter zero: low byte is 8-bit, counter zero controls.
// - Mode 3 on counter zero: high byte timer uses counter one's bits.
// - Counter one in mode 3 holds its count.
// - Config byte: counter one fields in bits 7..4, zero in 3..0.
// - Clock-select bit: 1 gives clock divided by 4, 0 by 12.
package tmr_pkg;

    localparam int ADDR_W = 12;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_RUN_CTRL  = 8'h88;
    localparam logic [7:0] IDX_OP_CFG    = 8'h89;
    localparam logic [7:0] IDX_C0_LOW    = 8'h8a;
    localparam logic [7:0] IDX_C1_LOW    = 8'h8b;
    localparam logic [7:0] IDX_C0_HIGH   = 8'h8c;
    localparam logic [7:0] IDX_C1_HIGH   = 8'h8d;
    localparam logic [7:0] IDX_CLK_CTRL  = 8'h8e;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'hc0;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'hc1;

    localparam logic [ADDR_W-1:0] ADDR_RUN_CTRL = {2'b00, IDX_RUN_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_OP_CFG   = {2'b00, IDX_OP_CFG, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_C0_LOW   = {2'b00, IDX_C0_LOW, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_C1_LOW   = {2'b00, IDX_C1_LOW, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_C0_HIGH  = {2'b00, IDX_C0_HIGH, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_C1_HIGH  = {2'b00, IDX_C1_HIGH, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CLK_CTRL = {2'b00, IDX_CLK_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = {2'b00, IDX_IRQ_STAT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};

    // Field positions in the run and flag control byte.
    localparam int POS_OVF_ONE  = 7;
    localparam int POS_RUN_ONE  = 6;
    localparam int POS_OVF_ZERO = 5;
    localparam int POS_RUN_ZERO = 4;
    localparam int POS_REQ_ONE  = 3;
    localparam int POS_TYPE_ONE = 2;
    localparam int POS_REQ_ZERO = 1;
    localparam int POS_TYPE_ZERO = 0;

    // Field positions in one nibble of the operating configuration byte.
    localparam int POS_GATE = 3;
    localparam int POS_SRC  = 2;
    localparam int CFG_ONE_LSB = 4;

    // Clock-control select bits.
    localparam int POS_DIV_SEL_ONE  = 4;
    localparam int POS_DIV_SEL_ZERO = 3;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIBBLE = 4'h0;

    // Internal count clock dividers, in reference clock cycles.
    localparam int DIV_SLOW = 12;
    localparam int DIV_FAST = 4;
    localparam logic [3:0] DIV_SLOW_LAST = 4'(DIV_SLOW - 1);
    localparam logic [1:0] DIV_FAST_LAST = 2'(DIV_FAST - 1);

    typedef enum logic [1:0] {
        MODE_PRESCALE = 2'b00,
        MODE_WIDE     = 2'b01,
        MODE_RELOAD   = 2'b10,
        MODE_SPLIT    = 2'b11
    } op_mode_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
        logic [3:0]        pstrb;
    } apb_req_t;

    typedef struct packed {
        logic ext_irq_one_pin;
        logic ext_irq_zero_pin;
        logic event_input_one;
        logic event_input_zero;
    } timer_pins_t;

    typedef struct packed {
        logic ovf_one;
        logic ovf_zero;
        logic ext_req_one;
        logic ext_req_zero;
    } req_flags_t;

    typedef struct packed {
        logic ovf_one;
        logic ovf_zero;
        logic ext_one;
        logic ext_zero;
    } svc_enter_t;

endpackage : tmr_pkg

// >>> verif/dual_timer_counter_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dual_timer_counter_checker (
    // Clock and reset.
    input wire logic                 ref_clk_i,
    input wire logic                 rst_n_i,
    // Watched ports.
    input wire tmr_pkg::apb_req_t    apb_i,
    input wire logic [31:0]          prdata_o,
    input wire logic                 pready_o,
    input wire logic                 pslverr_o,
    input wire tmr_pkg::timer_pins_t pins_i,
    input wire tmr_pkg::svc_enter_t  svc_enter_i,
    input wire tmr_pkg::req_flags_t  flags_o,
    input wire logic                 irq_o
);
    import tmr_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic wr_done;
    assign wr_done = apb_i.psel && apb_i.penable && apb_i.pwrite && pready_o;
    property p_ready_after; apb_i.psel && apb_i.penable && !pready_o |=> pready_o; endproperty
    a_ready_after: assert property (p_ready_after) else $error("late pready");
    property p_ready_pulse; pready_o |=> !pready_o; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_err_ready; pslverr_o |-> pready_o; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
    property p_data_holds; !pready_o |-> $stable(prdata_o); endproperty
    a_data_holds: assert property (p_data_holds) else $error("prdata moved");
    property p_ovf_clear;
        $fell(flags_o.ovf_zero) |-> $past(svc_enter_i.ovf_zero) || $past(wr_done);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("ovf cleared");
    property p_ext_set;
        $rose(flags_o.ext_req_zero)
            |-> $past(!pins_i.ext_irq_zero_pin, 2) || $past(wr_done);
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("request no cause");
    property p_irq_rise;
        $rose(irq_o) |-> (4'(flags_o) != 4'h0) || $past(wr_done);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq no cause");
    property p_irq_fall; $fell(irq_o) |-> $past(wr_done); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
    c_err: cover property (wr_done && pslverr_o);
    c_ovf_one: cover property ($rose(flags_o.ovf_one));
    c_irq: cover property ($rose(irq_o));
endmodule : dual_timer_counter_checker
bind dual_timer_counter dual_timer_counter_checker u_checker (.ref_clk_i, .rst_n_i,
    .apb_i, .prdata_o, .pready_o, .pslverr_o, .pins_i, .svc_enter_i, .flags_o, .irq_o);
`default_nettype wire

// >>> verif/pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module pin_model (
    // Clock.
    input  wire logic                 clk_i,
    // Pins towards the timer.
    output var  tmr_pkg::timer_pins_t pins_o
);
    import tmr_pkg::*;
    logic [3:0] level_reg;
    // Released pins sit high, as their pull-ups leave them.
    initial level_reg = 4'hf;
    assign pins_o = level_reg;
    task automatic drive(input int b, input logic v);
        @(posedge clk_i);
        level_reg[b] <= v;
    endtask
    // Each level is held four cycles so the synchroniser sees it.
    task automatic fall(input int b, input int n);
        repeat (n) begin
            drive(b, 1'b0);
            repeat (3) @(posedge clk_i);
            drive(b, 1'b1);
            repeat (3) @(posedge clk_i);
        end
    endtask
endmodule : pin_model
`default_nettype wire

// >>> verif/test_dual_timer_counter_ext_irq.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH %0t: got %h expected %h", $time, got, exp); end end
module test_dual_timer_counter_ext_irq;
    import tmr_pkg::*;
    logic        ref_clk_i;
    logic        rst_n_i;
    apb_req_t    apb_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    timer_pins_t pins_i;
    svc_enter_t  svc_enter_i;
    req_flags_t  flags_o;
    logic        irq_o;
    int          mismatches;
    int          cmp_count;
    logic [7:0]  q;
    logic        err;
    dual_timer_counter uut (.ref_clk_i, .rst_n_i, .apb_i, .prdata_o, .pready_o,
        .pslverr_o, .pins_i, .svc_enter_i, .flags_o, .irq_o);
    pin_model u_pins (.clk_i(ref_clk_i), .pins_o(pins_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task automatic report_and_stop;
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        apb_i <= '{1'b1, 1'b0, wr, a, 32'(d), 4'hf};
        @(posedge ref_clk_i);
        apb_i.penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        q = prdata_o[7:0];
        err = pslverr_o;
        apb_i <= '0;
        // Effects of a write land on this edge; let them settle first.
        @(negedge ref_clk_i);
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask
    task automatic svc(input svc_enter_t s);
        @(posedge ref_clk_i) svc_enter_i <= s;
        @(posedge ref_clk_i) svc_enter_i <= '0;
        @(posedge ref_clk_i);
    endtask
    // The sequence needs about 650 cycles.
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        report_and_stop();
    end
    initial begin
        apb_i = '0;
        svc_enter_i = '0;
        rst_n_i = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 6; i++) rd_chk(ADDR_RUN_CTRL + 12'(4 * i), RST_BYTE);
        apb(1'b0, 12'h010, 8'h00);
        `CHK({err, q}, 9'h100)
        apb(1'b1, ADDR_OP_CFG, 8'h05);
        apb(1'b1, ADDR_C0_LOW, 8'hfe);
        apb(1'b1, ADDR_C0_HIGH, 8'hff);
        apb(1'b1, ADDR_RUN_CTRL, 8'h10);
        u_pins.fall(0, 2);
        `CHK(flags_o.ovf_zero, 1'b1)
        rd_chk(ADDR_C0_LOW, 8'h00);
        rd_chk(ADDR_C0_HIGH, 8'h00);
        apb(1'b1, ADDR_RUN_CTRL, 8'h00);
        `CHK(flags_o.ovf_zero, 1'b0)
        u_pins.fall(0, 1);
        rd_chk(ADDR_C0_LOW, 8'h00);
        apb(1'b1, ADDR_RUN_CTRL, 8'h20);
        `CHK(flags_o.ovf_zero, 1'b1)
        svc(4'h4);
        `CHK(flags_o.ovf_zero, 1'b0)
        apb(1'b1, ADDR_IRQ_STAT, 8'h0f);
        apb(1'b1, ADDR_IRQ_MASK, 8'h04);
        apb(1'b1, ADDR_RUN_CTRL, 8'h01);
        u_pins.fall(2, 1);
        `CHK({flags_o.ext_req_zero, irq_o}, 2'h3)
        svc(4'h1);
        `CHK({flags_o.ext_req_zero, irq_o}, 2'h1)
        apb(1'b1, ADDR_IRQ_STAT, 8'h04);
        `CHK(irq_o, 1'b0)
        apb(1'b1, ADDR_IRQ_MASK, 8'h00);
        u_pins.fall(2, 1);
        `CHK({flags_o.ext_req_zero, irq_o}, 2'h2)
        apb(1'b1, ADDR_IRQ_MASK, 8'h04);
        `CHK(irq_o, 1'b1)
        apb(1'b1, ADDR_RUN_CTRL, 8'h00);
        u_pins.drive(2, 1'b0);
        repeat (5) @(posedge ref_clk_i);
        `CHK(flags_o.ext_req_zero, 1'b1)
        svc(4'h1);
        `CHK(flags_o.ext_req_zero, 1'b1)
        u_pins.drive(2, 1'b1);
        repeat (5) @(posedge ref_clk_i);
        `CHK(flags_o.ext_req_zero, 1'b0)
        apb(1'b1, ADDR_OP_CFG, 8'hd0);
        apb(1'b1, ADDR_RUN_CTRL, 8'h40);
        u_pins.drive(3, 1'b0);
        u_pins.fall(1, 2);
        rd_chk(ADDR_C1_LOW, 8'h00);
        `CHK(flags_o.ext_req_one, 1'b1)
        u_pins.drive(3, 1'b1);
        u_pins.fall(1, 2);
        rd_chk(ADDR_C1_LOW, 8'h02);
        `CHK(flags_o.ext_req_one, 1'b0)
        apb(1'b1, ADDR_OP_CFG, 8'h50);
        u_pins.drive(3, 1'b0);
        u_pins.fall(1, 3);
        rd_chk(ADDR_C1_LOW, 8'h05);
        u_pins.drive(3, 1'b1);
        apb(1'b1, ADDR_OP_CFG, 8'h06);
        apb(1'b1, ADDR_C0_HIGH, 8'h80);
        apb(1'b1, ADDR_C0_LOW, 8'hff);
        apb(1'b1, ADDR_RUN_CTRL, 8'h10);
        u_pins.fall(0, 1);
        rd_chk(ADDR_C0_LOW, 8'h80);
        `CHK(flags_o.ovf_zero, 1'b1)
        apb(1'b1, ADDR_OP_CFG, 8'h04);
        apb(1'b1, ADDR_C0_LOW, 8'hff);
        apb(1'b1, ADDR_C0_HIGH, 8'h00);
        u_pins.fall(0, 1);
        rd_chk(ADDR_C0_LOW, 8'he0);
        rd_chk(ADDR_C0_HIGH, 8'h01);
        apb(1'b1, ADDR_RUN_CTRL, 8'h00);
        apb(1'b1, ADDR_OP_CFG, 8'h37);
        apb(1'b1, ADDR_C0_HIGH, 8'hff);
        apb(1'b1, ADDR_C0_LOW, 8'h10);
        apb(1'b1, ADDR_C1_LOW, 8'h33);
        apb(1'b1, ADDR_RUN_CTRL, 8'h50);
        u_pins.fall(0, 1);
        u_pins.fall(1, 2);
        rd_chk(ADDR_C0_LOW, 8'h11);
        rd_chk(ADDR_C1_LOW, 8'h33);
        `CHK(flags_o.ovf_one, 1'b1)
        apb(1'b1, ADDR_OP_CFG, 8'h01);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, ADDR_CLK_CTRL, s ? 8'h08 : 8'h00);
            apb(1'b1, ADDR_C0_LOW, 8'h00);
            apb(1'b1, ADDR_RUN_CTRL, 8'h10);
            repeat (120) @(posedge ref_clk_i);
            apb(1'b1, ADDR_RUN_CTRL, 8'h00);
            apb(1'b0, ADDR_C0_LOW, 8'h00);
            `CHK(q >= (s ? 8'h1e : 8'h0a) && q <= (s ? 8'h20 : 8'h0b), 1'b1)
        end
        report_and_stop();
    end
endmodule : test_dual_timer_counter_ext_irq
`default_nettype wire
